// [clk_monitor_select.sv]
`timescale 1ns/10ps
// Purpose: External clock activity detector, stabilisation and source selection
// Assumes: internal inactivity and internal stable come from elsewhere, unsynchronised
// Notes:   Register port on clk; detector runs on the internal clock
module clk_monitor_select
	import clk_sel_pkg::*;
#(
	parameter int REF_DIV = REF_DIV_DFLT
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       internal_clock,
	input  wire logic       external_clock,
	input  wire logic       int_inactive_flag,
	input  wire logic       int_clock_stable,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	output logic            irq,
	output logic            ext_generator_enable,
	output logic            internal_clock_on,
	output logic            internal_reference_clock,
	output logic            osc_output_clock,
	output logic            timebase_clock,
	output logic            generator_output_clock
);

	localparam int DW = (REF_DIV > 2) ? $clog2(REF_DIV) : 1;
	localparam logic [DW-1:0] LOW_LAST = DW'(REF_DIV / 2 - 1);

	typedef struct packed {
		logic        en_m;
		logic        en_s;
		logic        xt_m;
		logic        xt_s;
		logic        off_m;
		logic        off_s;
		logic        tgl;
		logic [12:0] cnt;
		logic        done;
	} ext_s;

	typedef struct packed {
		logic [DW-1:0] div;
		logic          t_m;
		logic          t_s;
		logic          t_old;
		logic          seen;
		logic [1:0]    miss;
		logic          off;
	} int_s;

	typedef struct packed {
		logic       ext_on;
		logic       int_req;
		logic       int_on;
		logic       sel;
		logic       mon;
		logic       xtal;
		logic       done_m;
		logic       done_s;
		logic       ext_inactive_flag_m;
		logic       ext_inactive_flag_s;
		logic       int_inactive_flag_m;
		logic       int_inactive_flag_s;
		logic       ist_m;
		logic       ist_s;
		logic       ext_inactive_flag_d;
		logic       int_inactive_flag_d;
		logic       est_d;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic [7:0] rdata;
	} ctl_s;

	ext_s e_ff;
	ext_s nxt_e;
	int_s i_ff;
	int_s nxt_i;
	ctl_s c_ff;
	ctl_s nxt_c;
	logic gdiv_ff;
	logic nxt_gdiv;

	logic       st_ext;
	logic       st_int;
	logic       kill_ext;
	logic       kill_int;
	logic       hit;
	logic       end_low;
	logic       tgt_ok;
	logic [2:0] events;

	clk_switch_if osc_if ();
	clk_switch_if tb_if ();

	// ------------------------------------------------------------
	// External domain: edge toggle and stabilisation count
	// ------------------------------------------------------------
	always_comb begin
		nxt_e       = e_ff;
		nxt_e.en_m  = c_ff.ext_on;
		nxt_e.en_s  = e_ff.en_m;
		nxt_e.xt_m  = c_ff.xtal;
		nxt_e.xt_s  = e_ff.xt_m;
		nxt_e.off_m = i_ff.off;
		nxt_e.off_s = e_ff.off_m;
		nxt_e.tgl   = ~e_ff.tgl;
		if (!e_ff.en_s || e_ff.off_s) begin
			nxt_e.cnt  = 13'h0000;
			nxt_e.done = 1'b0;
		end else if (!e_ff.done) begin
			nxt_e.cnt = e_ff.cnt + 13'h0001;
			if (nxt_e.cnt == (e_ff.xt_s ? STAB_XTAL_CYC : STAB_PLAIN_CYC)) begin
				nxt_e.done = 1'b1;
			end
		end
	end

	// Falling edge of the external clock drives the stabilisation count
	always_ff @(negedge external_clock or posedge sys_rst) begin
		if (sys_rst) begin
			e_ff <= '0;
		end else begin
			e_ff <= nxt_e;
		end
	end

	// ------------------------------------------------------------
	// Internal domain: reference divider and activity detector
	// ------------------------------------------------------------
	// Toggle is sampled by the internal clock; a far faster external clock
	// can alias into missed edges, so keep the clock ratio modest
	assign hit     = ~i_ff.div[DW-1] & (i_ff.t_s ^ i_ff.t_old);
	assign end_low = (i_ff.div == LOW_LAST);

	always_comb begin
		nxt_i       = i_ff;
		nxt_i.div   = i_ff.div + DW'(1);
		nxt_i.t_m   = e_ff.tgl;
		nxt_i.t_s   = i_ff.t_m;
		nxt_i.t_old = i_ff.t_s;
		if (hit) begin
			nxt_i.off = 1'b0;
		end
		if (end_low) begin
			nxt_i.seen = 1'b0;
			if (i_ff.seen || hit) begin
				nxt_i.miss = 2'h0;
			end else if (i_ff.miss == MISS_LIMIT - 2'h1) begin
				nxt_i.off = 1'b1;
			end else begin
				nxt_i.miss = i_ff.miss + 2'h1;
			end
		end else if (hit) begin
			nxt_i.seen = 1'b1;
		end
	end

	always_ff @(posedge internal_clock or posedge sys_rst) begin
		if (sys_rst) begin
			i_ff <= '0;
		end else begin
			i_ff <= nxt_i;
		end
	end

	assign internal_reference_clock = i_ff.div[DW-1];

	// ------------------------------------------------------------
	// Register domain
	// ------------------------------------------------------------
	assign st_ext = c_ff.ext_on & c_ff.done_s & ~c_ff.ext_inactive_flag_s;
	assign st_int = c_ff.int_on & c_ff.ist_s & ~c_ff.int_inactive_flag_s;
	assign tgt_ok = wdata[CTRL_SEL] ? st_ext : st_int;
	assign events = {st_ext & ~c_ff.est_d, c_ff.int_inactive_flag_s & ~c_ff.int_inactive_flag_d, c_ff.ext_inactive_flag_s & ~c_ff.ext_inactive_flag_d};

	always_comb begin
		nxt_c        = c_ff;
		nxt_c.done_m = e_ff.done;
		nxt_c.done_s = c_ff.done_m;
		nxt_c.ext_inactive_flag_m = i_ff.off;
		nxt_c.ext_inactive_flag_s = c_ff.ext_inactive_flag_m;
		nxt_c.int_inactive_flag_m = int_inactive_flag;
		nxt_c.int_inactive_flag_s = c_ff.int_inactive_flag_m;
		nxt_c.ist_m  = int_clock_stable;
		nxt_c.ist_s  = c_ff.ist_m;
		nxt_c.ext_inactive_flag_d = c_ff.ext_inactive_flag_s;
		nxt_c.int_inactive_flag_d = c_ff.int_inactive_flag_s;
		nxt_c.est_d  = st_ext;
		nxt_c.rdata  = 8'h00;
		if (wr_stb && addr == OFF_CTRL) begin
			nxt_c.ext_on  = wdata[CTRL_EXT_ON];
			nxt_c.int_req = wdata[CTRL_INT_ON];
			nxt_c.xtal    = wdata[CTRL_XTAL];
			if (wdata[CTRL_SEL] != c_ff.sel && c_ff.ext_on && c_ff.int_on && tgt_ok) begin
				nxt_c.sel = wdata[CTRL_SEL];
			end
			if (!wdata[CTRL_MON]) begin
				nxt_c.mon = 1'b0;
			end else if (c_ff.ext_on && c_ff.int_on && st_ext && st_int) begin
				nxt_c.mon = 1'b1;
			end
		end
		if (wr_stb && addr == OFF_IRQ_MASK) begin
			nxt_c.irq_mask = wdata[2:0];
		end
		// Keep the select bit truthful after a forced switch-over
		if (c_ff.mon && c_ff.ext_inactive_flag_s && !c_ff.int_inactive_flag_s) begin
			nxt_c.sel = 1'b0;
		end else if (c_ff.mon && c_ff.int_inactive_flag_s && !c_ff.ext_inactive_flag_s) begin
			nxt_c.sel = 1'b1;
		end
		nxt_c.int_on = c_ff.int_req | ~c_ff.sel;
		if (rd_stb) begin
			case (addr)
				OFF_CTRL: begin
					nxt_c.rdata = {3'h0, c_ff.xtal, c_ff.mon, c_ff.sel, c_ff.int_on, c_ff.ext_on};
				end
				OFF_STATUS: begin
					nxt_c.rdata = {4'h0, c_ff.int_inactive_flag_s, c_ff.ext_inactive_flag_s, st_int, st_ext};
				end
				OFF_IRQ_STAT: begin
					nxt_c.rdata = {5'h00, c_ff.irq_stat};
				end
				OFF_IRQ_MASK: begin
					nxt_c.rdata = {5'h00, c_ff.irq_mask};
				end
				default: begin
					nxt_c.rdata = 8'h00;
				end
			endcase
		end
		// Set wins over the read-clear in the same cycle
		if (rd_stb && addr == OFF_IRQ_STAT) begin
			nxt_c.irq_stat = events;
		end else begin
			nxt_c.irq_stat = c_ff.irq_stat | events;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			c_ff <= '{ext_on: 1'b0, int_req: 1'b1, int_on: 1'b1, sel: 1'b0, irq_mask: IRQ_MASK_RST, default: '0};
		end else begin
			c_ff <= nxt_c;
		end
	end

	assign rdata                = c_ff.rdata;
	assign irq                  = |(c_ff.irq_stat & c_ff.irq_mask);
	assign ext_generator_enable = c_ff.ext_on;
	assign internal_clock_on    = c_ff.int_on;

	// ------------------------------------------------------------
	// Clock switches
	// ------------------------------------------------------------
	// Kill lines act at once; a dead clock cannot clock its own side out
	assign kill_ext = c_ff.mon & i_ff.off;
	assign kill_int = c_ff.mon & int_inactive_flag;

	assign osc_if.clk_a  = internal_clock;
	assign osc_if.clk_b  = external_clock;
	assign osc_if.rst    = sys_rst;
	assign osc_if.kill_a = kill_int;
	assign osc_if.kill_b = kill_ext;
	assign osc_if.sel_b  = kill_int | (c_ff.sel & ~kill_ext);

	assign tb_if.clk_a  = internal_clock;
	assign tb_if.clk_b  = external_clock;
	assign tb_if.rst    = sys_rst;
	assign tb_if.kill_a = kill_int;
	assign tb_if.kill_b = kill_ext;
	assign tb_if.sel_b  = kill_int | (c_ff.ext_on & ~kill_ext);

	glitch_free_switch u_osc_switch (
		.port_if (osc_if.sw)
	);

	glitch_free_switch u_tb_switch (
		.port_if (tb_if.sw)
	);

	assign osc_output_clock = osc_if.clk_out;
	assign timebase_clock   = tb_if.clk_out;

	// ------------------------------------------------------------
	// Divide by two
	// ------------------------------------------------------------
	assign nxt_gdiv = ~gdiv_ff;

	always_ff @(posedge osc_output_clock or posedge sys_rst) begin
		if (sys_rst) begin
			gdiv_ff <= 1'b0;
		end else begin
			gdiv_ff <= nxt_gdiv;
		end
	end

	assign generator_output_clock = gdiv_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ext_off_event: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(c_ff.ext_inactive_flag_s) |=> c_ff.irq_stat[EV_EXT_OFF]) else $error("dead clock event not latched");
	a_miss_twice: assert property (@(posedge internal_clock) disable iff (sys_rst)
		(end_low && !hit && !i_ff.seen && i_ff.miss == 2'h1) |=> i_ff.off) else $error("flag not set after two misses");
	a_hit_clears: assert property (@(posedge internal_clock) disable iff (sys_rst)
		hit |=> !i_ff.off) else $error("flag not cleared by edge");
	a_stable_needs_done: assert property (@(posedge clk) disable iff (sys_rst)
		st_ext |-> c_ff.done_s && c_ff.ext_on) else $error("stable without count");
	a_stable_drops: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(c_ff.ext_inactive_flag_s) |-> ##[0:1] !st_ext) else $error("stable kept while dead");
	a_sel_guard: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_stb && addr == OFF_CTRL && !c_ff.ext_on && !c_ff.mon) |=> $stable(c_ff.sel)) else $error("select moved");
	a_int_on_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!c_ff.sel ##1 !c_ff.sel |-> c_ff.int_on) else $error("internal off while selected");
	a_forced_int: assert property (@(posedge clk) disable iff (sys_rst)
		(c_ff.mon && c_ff.ext_inactive_flag_s && !c_ff.int_inactive_flag_s) |=> !c_ff.sel) else $error("no forced internal");
	a_forced_ext: assert property (@(posedge clk) disable iff (sys_rst)
		(c_ff.mon && c_ff.int_inactive_flag_s && !c_ff.ext_inactive_flag_s) |=> c_ff.sel) else $error("no forced external");
	a_sel_to_ext: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(c_ff.sel) |-> $past(st_ext || (c_ff.mon && c_ff.int_inactive_flag_s))) else $error("select moved too early");
	a_sel_to_int: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(c_ff.sel) |-> $past(st_int || (c_ff.mon && c_ff.ext_inactive_flag_s))) else $error("select moved too early");
	a_int_on_clear: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(c_ff.int_on) |-> $past(c_ff.sel)) else $error("internal off while still selected");
	a_mon_guard: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(c_ff.mon) |-> $past(st_ext && st_int)) else $error("monitor on without stable sources");
	a_kill_deselect: assert property (@(posedge clk) disable iff (sys_rst)
		(kill_ext && !kill_int) |-> !osc_if.sel_b && !tb_if.sel_b) else $error("dead external still selected");
	a_stable_count: assert property (@(negedge external_clock) disable iff (sys_rst)
		$rose(e_ff.done) |-> e_ff.cnt == ($past(e_ff.xt_s) ? STAB_XTAL_CYC : STAB_PLAIN_CYC))
		else $error("stable at wrong count");
	a_div_toggles: assert property (@(posedge osc_output_clock) disable iff (sys_rst)
		!$past(sys_rst) |-> gdiv_ff != $past(gdiv_ff)) else $error("output clock not halved");

	c_switch_ext: cover property (@(posedge clk) disable iff (sys_rst) $rose(c_ff.sel));
	c_forced: cover property (@(posedge clk) disable iff (sys_rst) c_ff.mon && c_ff.ext_inactive_flag_s);
	c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
	c_resume: cover property (@(posedge clk) disable iff (sys_rst) $fell(c_ff.ext_inactive_flag_s));
	c_xtal_stable: cover property (@(posedge clk) disable iff (sys_rst) $rose(st_ext) && c_ff.xtal);

endmodule

// [clk_sel_pkg.sv]
// Purpose: Shared constants and types of the clock monitor and source selector
// Assumes: 8-bit register port on clk; two free, mutually asynchronous source clocks
// Notes:   Offsets, bit positions and interrupt events are local choices
package clk_sel_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_CTRL     = 4'h0;
	localparam logic [3:0] OFF_STATUS   = 4'h4;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFF_IRQ_MASK = 4'hC;

	localparam int CTRL_EXT_ON = 0;
	localparam int CTRL_INT_ON = 1;
	localparam int CTRL_SEL    = 2;
	localparam int CTRL_MON    = 3;
	localparam int CTRL_XTAL   = 4;

	localparam int ST_EXT_STABLE = 0;
	localparam int ST_INT_STABLE = 1;
	localparam int ST_EXT_OFF    = 2;
	localparam int ST_INT_OFF    = 3;

	localparam int EV_EXT_OFF    = 0;
	localparam int EV_INT_OFF    = 1;
	localparam int EV_EXT_STABLE = 2;

	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

	// ------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------
	localparam logic [12:0] STAB_XTAL_CYC  = 13'h1000;
	localparam logic [12:0] STAB_PLAIN_CYC = 13'h0010;
	localparam int          REF_DIV_DFLT   = 4;
	localparam logic [1:0]  MISS_LIMIT     = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic q1;
		logic q2;
	} side_s;

endpackage

// [clk_switch_if.sv]
`timescale 1ns/10ps
// Purpose: Carries both sources, the select and the kill lines into one switch
// Assumes: side a is the internal clock, side b the external clock
// Notes:   kill lines are asynchronous clears of the dead side
interface clk_switch_if;
	logic clk_a;
	logic clk_b;
	logic rst;
	logic sel_b;
	logic kill_a;
	logic kill_b;
	logic clk_out;

	modport ctrl (output clk_a, output clk_b, output rst, output sel_b, output kill_a, output kill_b, input clk_out);
	modport sw   (input clk_a, input clk_b, input rst, input sel_b, input kill_a, input kill_b, output clk_out);
endinterface

// [glitch_free_switch.sv]
`timescale 1ns/10ps
// Purpose: Glitch-free switch between two asynchronous clocks
// Assumes: both clocks toggle while their side is being handed over
// Notes:   Hand-over length varies by one cycle on each side, by nature
module glitch_free_switch
	import clk_sel_pkg::*;
(
	clk_switch_if.sw port_if
);

	side_s a_ff;
	side_s nxt_a;
	side_s b_ff;
	side_s nxt_b;

	// ------------------------------------------------------------
	// Cross-coupled enables
	// ------------------------------------------------------------
	always_comb begin
		nxt_a    = a_ff;
		nxt_b    = b_ff;
		nxt_a.q1 = ~port_if.sel_b & ~b_ff.q2;
		nxt_a.q2 = a_ff.q1;
		nxt_b.q1 = port_if.sel_b & ~a_ff.q2;
		nxt_b.q2 = b_ff.q1;
	end

	// Falling-edge flops, so enables change while their clock is low
	always_ff @(negedge port_if.clk_a or posedge port_if.rst or posedge port_if.kill_a) begin
		if (port_if.rst) begin
			a_ff <= 2'h3;
		end else if (port_if.kill_a) begin
			a_ff <= 2'h0;
		end else begin
			a_ff <= nxt_a;
		end
	end

	always_ff @(negedge port_if.clk_b or posedge port_if.rst or posedge port_if.kill_b) begin
		if (port_if.rst) begin
			b_ff <= 2'h0;
		end else if (port_if.kill_b) begin
			b_ff <= 2'h0;
		end else begin
			b_ff <= nxt_b;
		end
	end

	assign port_if.clk_out = (port_if.clk_a & a_ff.q2) | (port_if.clk_b & b_ff.q2);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_one_source: assert property (@(posedge port_if.clk_a) disable iff (port_if.rst)
		!(a_ff.q2 && b_ff.q2)) else $error("both switch sides enabled");
	a_b_takes_two: assert property (@(negedge port_if.clk_b) disable iff (port_if.rst || port_if.kill_b)
		$rose(b_ff.q2) |-> $past(b_ff.q1) && !a_ff.q2) else $error("b side enabled without sync");

endmodule

// [tb_clk_monitor_select.sv]
`timescale 1ns/10ps
// Purpose: Self-checking bench for the clock monitor and source selector
// Assumes: Sources run fast enough to see two edges each within the reset hold
// Notes:   External source can be stopped and restarted to provoke the monitor
module tb_clk_monitor_select
	import clk_sel_pkg::*;
;
	localparam logic [7:0] B_EXT = 8'h01 << CTRL_EXT_ON;
	localparam logic [7:0] B_INT = 8'h01 << CTRL_INT_ON;
	localparam logic [7:0] B_SEL = 8'h01 << CTRL_SEL;
	localparam logic [7:0] B_MON = 8'h01 << CTRL_MON;
	localparam logic [7:0] B_XTL = 8'h01 << CTRL_XTAL;

	logic       clk, sys_rst, internal_clock, external_clock, ext_run;
	logic       int_inactive_flag, int_clock_stable, wr_stb, rd_stb;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, d;
	logic       irq, ext_generator_enable, internal_clock_on, internal_reference_clock;
	logic       osc_output_clock, timebase_clock, generator_output_clock;
	int         n_fail, samples_checked, ext_falls;

	// ------------------------------------------------------------
	// Clocks
	// ------------------------------------------------------------
	always #5 clk = ~clk;
	always #4.1 internal_clock = ~internal_clock;
	// Stopped source parks low, as a dead oscillator would
	always #3.7 external_clock = ext_run ? ~external_clock : 1'b0;
	always @(negedge external_clock) ext_falls++;

	clk_monitor_select #(.REF_DIV(4)) DUT (
		.clk                      (clk),
		.sys_rst                  (sys_rst),
		.internal_clock           (internal_clock),
		.external_clock           (external_clock),
		.int_inactive_flag        (int_inactive_flag),
		.int_clock_stable         (int_clock_stable),
		.addr                     (addr),
		.wdata                    (wdata),
		.wr_stb                   (wr_stb),
		.rd_stb                   (rd_stb),
		.rdata                    (rdata),
		.irq                      (irq),
		.ext_generator_enable     (ext_generator_enable),
		.internal_clock_on        (internal_clock_on),
		.internal_reference_clock (internal_reference_clock),
		.osc_output_clock         (osc_output_clock),
		.timebase_clock           (timebase_clock),
		.generator_output_clock   (generator_output_clock)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr   <= a;
		wdata  <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 q = rdata;
	endtask

	// Poll costs a few cycles per try, so bounds on edge counts carry slack
	task automatic poll(input logic [3:0] a, input int b, input logic v, input int lim);
		logic [7:0] r;
		for (int i = 0; i < lim; i++) begin
			rd(a, r);
			if (r[b] === v)
				return;
		end
		n_fail++;
		$display("BAD %0t status wait ran out", $time);
		wrap_up();
	endtask

	// Only compares when the source was steady, so edge races are skipped
	task automatic follow(input bit tb, input bit ext);
		logic s1, o;
		repeat (24) begin
			#1.3;
			s1 = ext ? external_clock : internal_clock;
			#0.2;
			o = tb ? timebase_clock : osc_output_clock;
			if (s1 === (ext ? external_clock : internal_clock))
				chk({7'h0, o}, {7'h0, s1});
		end
	endtask

	task automatic div2_chk();
		logic g;
		@(posedge osc_output_clock);
		#0.1 g = generator_output_clock;
		repeat (6) begin
			@(posedge osc_output_clock);
			#0.1;
			chk({7'h0, generator_output_clock}, {7'h0, ~g});
			g = generator_output_clock;
		end
	endtask

	initial begin
		#300us;
		n_fail++;
		$display("BAD %0t run hung", $time);
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 0; internal_clock = 0; external_clock = 0; ext_run = 1; sys_rst = 1;
		int_inactive_flag = 0; int_clock_stable = 1; addr = 0; wdata = 0;
		wr_stb = 0; rd_stb = 0; n_fail = 0; samples_checked = 0; ext_falls = 0;
		repeat (2) @(posedge clk);
		#1 chk({4'h0, ext_generator_enable, internal_clock_on, generator_output_clock, irq}, 8'h04);
		@(posedge clk) sys_rst <= 1'b0;
		rd(OFF_CTRL, d); chk(d, B_INT);
		rd(OFF_IRQ_MASK, d); chk(d, {5'h0, IRQ_MASK_RST});
		rd(4'h2, d); chk(d, 8'h00);
		follow(0, 0);
		follow(1, 0);
		@(posedge internal_reference_clock);
		repeat (2) @(posedge internal_clock);
		#0.1 chk({7'h0, internal_reference_clock}, 8'h00);
		repeat (2) @(posedge internal_clock);
		#0.1 chk({7'h0, internal_reference_clock}, 8'h01);
		// Select refused with external off; internal-on clear deferred
		wr(OFF_CTRL, B_SEL);
		rd(OFF_CTRL, d); chk(d, B_INT);
		chk({7'h0, internal_clock_on}, 8'h01);
		// Short stabilisation
		wr(OFF_IRQ_MASK, 8'h01 << EV_EXT_STABLE);
		ext_falls = 0;
		wr(OFF_CTRL, B_EXT | B_INT);
		#1 chk({7'h0, ext_generator_enable}, 8'h01);
		poll(OFF_STATUS, ST_EXT_STABLE, 1'b1, 100);
		chk({7'h0, ext_falls >= 16 && ext_falls <= 28}, 8'h01);
		chk({7'h0, irq}, 8'h01);
		rd(OFF_IRQ_STAT, d); chk(d, 8'h01 << EV_EXT_STABLE);
		rd(OFF_IRQ_STAT, d); chk(d, 8'h00);
		chk({7'h0, irq}, 8'h00);
		follow(1, 1);
		follow(0, 0);
		// Switch the oscillator clock to external
		wr(OFF_CTRL, B_EXT | B_INT | B_SEL);
		rd(OFF_CTRL, d); chk(d, B_EXT | B_INT | B_SEL);
		repeat (20) @(posedge clk);
		follow(0, 1);
		div2_chk();
		// Monitor on, then the external source dies
		wr(OFF_CTRL, B_EXT | B_INT | B_SEL | B_MON);
		rd(OFF_CTRL, d); chk(d, B_EXT | B_INT | B_SEL | B_MON);
		wr(OFF_IRQ_MASK, 8'h01 << EV_EXT_OFF);
		ext_run <= 1'b0;
		poll(OFF_STATUS, ST_EXT_OFF, 1'b1, 100);
		chk({7'h0, irq}, 8'h01);
		rd(OFF_STATUS, d); chk(d & 8'h01 << ST_EXT_STABLE, 8'h00);
		rd(OFF_CTRL, d); chk(d & B_SEL, 8'h00);
		repeat (4) @(posedge clk);
		follow(0, 0);
		follow(1, 0);
		rd(OFF_IRQ_STAT, d); chk(d, 8'h01 << EV_EXT_OFF);
		ext_run <= 1'b1;
		poll(OFF_STATUS, ST_EXT_OFF, 1'b0, 100);
		// Internal inactivity event, left masked
		wr(OFF_CTRL, B_EXT | B_INT);
		// Let the monitor clear first, so no zero-width kill pulse
		@(posedge clk);
		int_inactive_flag <= 1'b1;
		repeat (6) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		rd(OFF_IRQ_STAT, d); chk(d & 8'h01 << EV_INT_OFF, 8'h01 << EV_INT_OFF);
		int_inactive_flag <= 1'b0;
		// Generator off clears stable; timebase back on internal
		wr(OFF_CTRL, B_INT);
		repeat (6) @(posedge clk);
		rd(OFF_STATUS, d); chk(d & 8'h01 << ST_EXT_STABLE, 8'h00);
		repeat (10) @(posedge clk);
		follow(1, 0);
		// Crystal stabilisation, the long count
		ext_falls = 0;
		wr(OFF_CTRL, B_INT | B_EXT | B_XTL);
		poll(OFF_STATUS, ST_EXT_STABLE, 1'b1, 2000);
		chk({7'h0, ext_falls >= 4096 && ext_falls <= 4112}, 8'h01);
		wrap_up();
	end
endmodule
